// ===== logic/asq_cfg.svh
// Constants for the step 14 configuration register of the auxiliary sequencer.
// Assumes AXI4-Lite with 32-bit data; register indices are word indices.
//
// Contract
// - Bit 15 set includes step 14, cleared excludes.
// - Gain bits 14:13: 00=1, 01=2, 1x=4.
// - Bit 4: 0 ground reference, 1 analog input 7.
// - Positive codes 0000..0111 select analog inputs 0..7.
// - Code 1000 temperature, 1001 internal short, auto negative.
// - Automatic negative codes ignore the negative-input bit.
// - Register at index 9Eh, resets to 000Eh.
`ifndef ASQ_CFG_SVH
`define ASQ_CFG_SVH

`define ASQ_ADDR_W 12
`define ASQ_CFG_INDEX 10'h09e
`define ASQ_CFG_RESET 16'h000e
`define ASQ_CFG_WMASK 16'he01f
`define ASQ_EN_BIT 15
`define ASQ_GAIN_MSB 14
`define ASQ_GAIN_LSB 13
`define ASQ_RSV_MSB 12
`define ASQ_RSV_LSB 5
`define ASQ_NEG_BIT 4
`define ASQ_POS_MSB 3
`define ASQ_POS_LSB 0
`define ASQ_POS_TEMP 4'h8
`define ASQ_POS_SHORT 4'h9
`define ASQ_RESP_OKAY 2'h0
`define ASQ_RESP_DECERR 2'h3

`endif

// ===== logic/asq_pkg.sv
// Types shared by the step 14 configuration register and its field decoder.
// Assumes the constants header is included by each user.
package asq_pkg;

	typedef enum logic [1:0] {
		ASQ_GAIN_X1,
		ASQ_GAIN_X2,
		ASQ_GAIN_X4
	} asq_gain_t;

	typedef enum logic [1:0] {
		ASQ_NEG_GND,
		ASQ_NEG_AIN7,
		ASQ_NEG_AUTO
	} asq_neg_t;

	typedef enum logic [1:0] {
		ASQ_POS_AIN,
		ASQ_POS_TEMP,
		ASQ_POS_SHORT,
		ASQ_POS_OTHER
	} asq_pos_t;

endpackage

// ===== logic/asq_field_decode.sv
// Field decoder for the step 14 configuration word.
// Assumes the word comes from a register on the same clock.
`timescale 1ns/100ps
`include "asq_cfg.svh"

module asq_field_decode
	import asq_pkg::*;
(
	input logic ref_clk_i,
	input logic rst_n_i,
	input logic [15:0] cfg_i,
	output logic step_en_o,
	output asq_gain_t gain_o,
	output asq_pos_t pos_kind_o,
	output logic [2:0] pos_ain_o,
	output logic [3:0] pos_code_o,
	output asq_neg_t neg_o
);

	wire [3:0] code_w = cfg_i[`ASQ_POS_MSB:`ASQ_POS_LSB];
	wire [1:0] gsel_w = cfg_i[`ASQ_GAIN_MSB:`ASQ_GAIN_LSB];
	// Every code from 1000 upward picks its own negative input
	wire auto_neg_w = code_w[3];
	wire asq_gain_t gain_w = (gsel_w == 2'h0) ? ASQ_GAIN_X1 :
		(gsel_w == 2'h1) ? ASQ_GAIN_X2 : ASQ_GAIN_X4;
	wire asq_pos_t pos_w = !code_w[3] ? ASQ_POS_AIN :
		(code_w == `ASQ_POS_TEMP) ? ASQ_POS_TEMP :
		(code_w == `ASQ_POS_SHORT) ? ASQ_POS_SHORT : ASQ_POS_OTHER;
	wire asq_neg_t neg_w = auto_neg_w ? ASQ_NEG_AUTO :
		(cfg_i[`ASQ_NEG_BIT] ? ASQ_NEG_AIN7 : ASQ_NEG_GND);

	// Outputs are registered so the analog controls never see decode glitches
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			step_en_o <= 1'b0;
			gain_o <= ASQ_GAIN_X1;
			pos_kind_o <= ASQ_POS_OTHER;
			pos_ain_o <= 3'h0;
			pos_code_o <= 4'he;
			neg_o <= ASQ_NEG_AUTO;
		end else begin
			step_en_o <= cfg_i[`ASQ_EN_BIT];
			gain_o <= gain_w;
			pos_kind_o <= pos_w;
			pos_ain_o <= code_w[2:0];
			pos_code_o <= code_w;
			neg_o <= neg_w;
		end
	end

endmodule

// ===== logic/asq_step14_cfg.sv
// Step 14 configuration register of the auxiliary converter sequencer,
// reached as an AXI4-Lite slave, with the decoded fields driven out.
// Assumes one write and one read outstanding at most, on one clock.
`timescale 1ns/100ps
`include "asq_cfg.svh"

module asq_step14_cfg
	import asq_pkg::*;
(
	input logic ref_clk_i,
	input logic rst_n_i,
	input logic [`ASQ_ADDR_W-1:0] s_axi_awaddr_i,
	input logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input logic [31:0] s_axi_wdata_i,
	input logic [3:0] s_axi_wstrb_i,
	input logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input logic s_axi_bready_i,
	input logic [`ASQ_ADDR_W-1:0] s_axi_araddr_i,
	input logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input logic s_axi_rready_i,
	output logic [15:0] cfg_word_o,
	output logic step14_enable_o,
	output asq_gain_t step14_gain_o,
	output asq_pos_t step14_pos_kind_o,
	output logic [2:0] step14_pos_ain_o,
	output logic [3:0] step14_positive_input_select_o,
	output asq_neg_t step14_neg_o
);

	logic aw_full_r;
	logic [`ASQ_ADDR_W-1:0] aw_addr_r;
	logic w_full_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic [15:0] cfg_r;
	logic [15:0] cfg_nxt;

	// Handshakes
	wire aw_take_w = s_axi_awvalid_i & ~aw_full_r;
	wire w_take_w = s_axi_wvalid_i & ~w_full_r;
	// A write commits only once both halves are held and the last response left
	wire do_write_w = aw_full_r & w_full_r & ~bvalid_r;
	wire ar_take_w = s_axi_arvalid_i & ~rvalid_r;

	// Address decode
	wire wr_hit_w = (aw_addr_r[`ASQ_ADDR_W-1:2] == `ASQ_CFG_INDEX);
	wire rd_hit_w = (s_axi_araddr_i[`ASQ_ADDR_W-1:2] == `ASQ_CFG_INDEX);
	wire wr_go_w = do_write_w & wr_hit_w;

	// Byte lanes above 15 carry nothing; reserved bits never load
	wire [15:0] lane_w = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
	wire [15:0] wmask_w = lane_w & `ASQ_CFG_WMASK;

	always_comb begin
		cfg_nxt = cfg_r;
		if (wr_go_w) begin
			cfg_nxt = (cfg_r & ~wmask_w) | (w_data_r[15:0] & wmask_w);
		end
	end

	// Read data: upper half and reserved bits come back as zero
	wire [31:0] rd_word_w = rd_hit_w ? {16'h0000, cfg_r} : 32'h0000_0000;
	wire [1:0] rd_resp_w = rd_hit_w ? `ASQ_RESP_OKAY : `ASQ_RESP_DECERR;
	wire [1:0] wr_resp_w = wr_hit_w ? `ASQ_RESP_OKAY : `ASQ_RESP_DECERR;

	assign s_axi_awready_o = ~aw_full_r;
	assign s_axi_wready_o = ~w_full_r;
	assign s_axi_bvalid_o = bvalid_r;
	assign s_axi_bresp_o = bresp_r;
	assign s_axi_arready_o = ~rvalid_r;
	assign s_axi_rvalid_o = rvalid_r;
	assign s_axi_rdata_o = rdata_r;
	assign s_axi_rresp_o = rresp_r;
	assign cfg_word_o = cfg_r;

	// Write address holding
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_full_r <= 1'b0;
		end else if (aw_take_w) begin
			aw_full_r <= 1'b1;
		end else if (do_write_w) begin
			aw_full_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_addr_r <= '0;
		end else if (aw_take_w) begin
			aw_addr_r <= s_axi_awaddr_i;
		end
	end

	// Write data holding
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			w_full_r <= 1'b0;
		end else if (w_take_w) begin
			w_full_r <= 1'b1;
		end else if (do_write_w) begin
			w_full_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else if (w_take_w) begin
			w_data_r <= s_axi_wdata_i;
			w_strb_r <= s_axi_wstrb_i;
		end
	end

	// Write response
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bvalid_r <= 1'b0;
			bresp_r <= `ASQ_RESP_OKAY;
		end else if (do_write_w) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_resp_w;
		end else if (s_axi_bready_i) begin
			bvalid_r <= 1'b0;
		end
	end

	// Read channel; data is captured at the address edge
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `ASQ_RESP_OKAY;
		end else if (ar_take_w) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_word_w;
			rresp_r <= rd_resp_w;
		end else if (s_axi_rready_i) begin
			rvalid_r <= 1'b0;
		end
	end

	// The configuration register itself
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_r <= `ASQ_CFG_RESET;
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	// Decoded fields lag the register by one cycle
	asq_field_decode u_decode (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.cfg_i(cfg_r),
		.step_en_o(step14_enable_o),
		.gain_o(step14_gain_o),
		.pos_kind_o(step14_pos_kind_o),
		.pos_ain_o(step14_pos_ain_o),
		.pos_code_o(step14_positive_input_select_o),
		.neg_o(step14_neg_o)
	);

	// Checks
	logic seen_wr_r;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			seen_wr_r <= 1'b0;
		end else if (wr_go_w) begin
			seen_wr_r <= 1'b1;
		end
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking

	default disable iff (!rst_n_i);

	sequence s_commit_hi;
		wr_go_w && w_strb_r[1];
	endsequence

	sequence s_commit_lo;
		wr_go_w && w_strb_r[0];
	endsequence

	sequence s_pair_held;
		aw_full_r && w_full_r && !bvalid_r;
	endsequence

	property p_enable_track;
		logic en;
		(s_commit_hi, en = w_data_r[15]) |=> ##1 (step14_enable_o == en);
	endproperty

	property p_pos_direct;
		logic [2:0] ch;
		(s_commit_lo and !w_data_r[3], ch = w_data_r[2:0])
			|=> ##1 (step14_pos_kind_o == ASQ_POS_AIN && step14_pos_ain_o == ch);
	endproperty

	a_enable_track: assert property (p_enable_track)
		else $error("Step enable output does not follow written bit");

	a_gain_quad: assert property (cfg_r[14] |=> step14_gain_o == ASQ_GAIN_X4)
		else $error("Gain code 1x did not give gain four");

	a_gain_low: assert property ((cfg_r[14:13] == 2'h1) |=> step14_gain_o == ASQ_GAIN_X2)
		else $error("Gain code 01 did not give gain two");

	a_neg_manual: assert property (!cfg_r[3] |=>
		step14_neg_o == ($past(cfg_r[4]) ? ASQ_NEG_AIN7 : ASQ_NEG_GND))
		else $error("Negative input does not match its select bit");

	a_pos_direct: assert property (p_pos_direct)
		else $error("Positive code below 1000 not mapped to its input");

	a_pos_short: assert property ((cfg_r[3:0] == 4'h9) |=>
		step14_pos_kind_o == ASQ_POS_SHORT && step14_neg_o == ASQ_NEG_AUTO)
		else $error("Internal short code decoded wrongly");

	a_pos_temp: assert property ((cfg_r[3:0] == 4'h8) |=> step14_pos_kind_o == ASQ_POS_TEMP)
		else $error("Temperature code decoded wrongly");

	a_neg_ignored: assert property (cfg_r[3] ##1 cfg_r[3] |=>
		step14_neg_o == ASQ_NEG_AUTO && $stable(step14_neg_o))
		else $error("Negative select bit leaked through an automatic code");

	a_reset_value: assert property (!seen_wr_r |-> cfg_r == `ASQ_CFG_RESET)
		else $error("Register left its reset value without a write");

	a_rsv_zero: assert property (rvalid_r |-> rdata_r[31:16] == 16'h0000 && rdata_r[12:5] == 8'h00)
		else $error("Reserved read bits are not zero");

	a_rsv_stuck: assert property (cfg_r[12:5] == 8'h00)
		else $error("Reserved register bits were written");

	a_bresp_time: assert property (s_pair_held |=> bvalid_r && s_axi_awready_o && s_axi_wready_o)
		else $error("Write response did not follow a held pair");

	a_read_hold: assert property (rvalid_r && !s_axi_rready_i |=> rvalid_r && $stable(rdata_r))
		else $error("Read data dropped before it was taken");

	a_gain_unity: assert property ((cfg_r[14:13] == 2'h0) |=> step14_gain_o == ASQ_GAIN_X1)
		else $error("Gain code 00 did not give gain one");

	a_neg_auto: assert property (cfg_r[3] |=> step14_neg_o == ASQ_NEG_AUTO)
		else $error("Internal source code did not pick the negative input itself");

	a_enable_level: assert property (step14_enable_o == $past(cfg_r[15]))
		else $error("Step enable output does not match the register");

	a_code_copy: assert property (step14_positive_input_select_o == $past(cfg_r[3:0]))
		else $error("Positive code output does not match the register");

	// Codes above the short decode as other sources, still with automatic negative input
	a_other_kind: assert property ((cfg_r[3:0] >= 4'ha) |=> step14_pos_kind_o == ASQ_POS_OTHER)
		else $error("Upper positive code decoded as a named source");

	a_read_value: assert property (s_axi_arvalid_i && s_axi_arready_o && rd_hit_w |=>
		rdata_r == {16'h0000, $past(cfg_r)} && rresp_r == `ASQ_RESP_OKAY)
		else $error("Read of the register returned the wrong word");

	a_read_miss: assert property (s_axi_arvalid_i && s_axi_arready_o && !rd_hit_w |=>
		rdata_r == 32'h0000_0000 && rresp_r == `ASQ_RESP_DECERR)
		else $error("Unmapped read was not refused");

	a_write_miss: assert property (do_write_w && !wr_hit_w |=>
		$stable(cfg_r) && bresp_r == `ASQ_RESP_DECERR)
		else $error("Unmapped write was not refused");

	a_write_ok: assert property (wr_go_w |=> bresp_r == `ASQ_RESP_OKAY)
		else $error("Write to the register was not acknowledged as okay");

	// Catches any stray load path, such as a read or a refused write touching the word
	a_idle_stable: assert property (!wr_go_w |=> $stable(cfg_r))
		else $error("Register changed without a write to it");

	a_bresp_hold: assert property (bvalid_r && !s_axi_bready_i |=> bvalid_r && $stable(bresp_r))
		else $error("Write response dropped before it was taken");

	a_rresp_hold: assert property (rvalid_r && !s_axi_rready_i |=> $stable(rresp_r))
		else $error("Read response changed before it was taken");

	a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> rvalid_r)
		else $error("Read answer did not follow its address");

	a_b_clear: assert property (bvalid_r && s_axi_bready_i |=> !bvalid_r)
		else $error("Write response stood after it was taken");

	a_r_clear: assert property (rvalid_r && s_axi_rready_i |=> !rvalid_r)
		else $error("Read answer stood after it was taken");

endmodule

// ===== dv/asq_step14_cfg_test.sv
// Self-checking bench for the step 14 configuration register and its decoded fields.
// Assumes the register answers on AXI4-Lite at byte address 0x278, one clock, async reset.
`timescale 1ns/100ps
`include "asq_cfg.svh"

module asq_step14_cfg_test
	import asq_pkg::*;
;
	`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
		$display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

	localparam logic [11:0] CFG_ADDR = 12'h278;
	localparam logic [11:0] BAD_ADDR = 12'h27c;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [11:0] araddr = 12'h000;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] cfg_word;
	logic en;
	asq_gain_t gain;
	asq_pos_t kind;
	logic [2:0] ain;
	logic [3:0] code;
	asq_neg_t neg;
	int error_cnt = 0;
	int cmp_count = 0;
	int b_delay = 0;
	int r_delay = 0;

	asq_step14_cfg u_dut (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.cfg_word_o(cfg_word), .step14_enable_o(en), .step14_gain_o(gain), .step14_pos_kind_o(kind),
		.step14_pos_ain_o(ain), .step14_positive_input_select_o(code), .step14_neg_o(neg)
	);

	initial begin
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	task automatic complete_run();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Address and data offered together; each released on its own handshake edge
	task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		fork
			begin
				do @(posedge ref_clk_i); while (awready !== 1'b1);
				awvalid <= 1'b0;
			end
			begin
				do @(posedge ref_clk_i); while (wready !== 1'b1);
				wvalid <= 1'b0;
			end
		join
		repeat (b_delay) @(posedge ref_clk_i);
		bready <= 1'b1;
		do @(posedge ref_clk_i); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge ref_clk_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		repeat (r_delay) @(posedge ref_clk_i);
		rready <= 1'b1;
		do @(posedge ref_clk_i); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// Decoded outputs are judged against the word the register should hold
	task automatic check_out(input logic [15:0] w);
		logic [31:0] d;
		logic [1:0] r;
		asq_pos_t ek;
		axi_read(CFG_ADDR, d, r);
		ek = ASQ_POS_OTHER;
		if (!w[3]) begin
			ek = ASQ_POS_AIN;
		end else if (w[3:0] == `ASQ_POS_TEMP) begin
			ek = ASQ_POS_TEMP;
		end else if (w[3:0] == `ASQ_POS_SHORT) begin
			ek = ASQ_POS_SHORT;
		end
		`CHK(r, `ASQ_RESP_OKAY)
		`CHK(d, {16'h0000, w})
		`CHK(cfg_word, w)
		`CHK(en, w[15])
		`CHK(gain, w[14] ? ASQ_GAIN_X4 : (w[13] ? ASQ_GAIN_X2 : ASQ_GAIN_X1))
		`CHK(code, w[3:0])
		`CHK(kind, ek)
		if (!w[3]) begin
			`CHK(ain, w[2:0])
		end
		`CHK(neg, w[3] ? ASQ_NEG_AUTO : (w[4] ? ASQ_NEG_AIN7 : ASQ_NEG_GND))
	endtask

	task automatic write_check(input logic [31:0] d, input logic [3:0] s, input logic [15:0] expw);
		logic [1:0] r;
		axi_write(CFG_ADDR, d, s, r);
		`CHK(r, `ASQ_RESP_OKAY)
		// Decoded fields land one edge after commit
		repeat (3) @(posedge ref_clk_i);
		check_out(expw);
	endtask

	task automatic t_reset();
		check_out(16'h000e);
	endtask

	task automatic t_reserved();
		write_check(32'hffff_ffff, 4'hf, 16'he01f);
		// Only lane 0 written, so the upper byte keeps its value
		write_check(32'h0000_0000, 4'h1, 16'he000);
	endtask

	task automatic t_fields();
		logic [15:0] w;
		for (int g = 0; g < 4; g++) begin
			for (int c = 0; c < 16; c++) begin
				w = {g[0], g[1:0], 8'h00, c[0] ^ g[0], c[3:0]};
				write_check({16'hffff, w}, 4'hf, w);
			end
		end
	endtask

	task automatic t_unmapped();
		logic [31:0] d;
		logic [1:0] r;
		write_check(32'h0000_a015, 4'h3, 16'ha015);
		axi_write(BAD_ADDR, 32'h0000_0000, 4'hf, r);
		`CHK(r, `ASQ_RESP_DECERR)
		axi_read(BAD_ADDR, d, r);
		`CHK(r, `ASQ_RESP_DECERR)
		`CHK(d, 32'h0000_0000)
		check_out(16'ha015);
	endtask

	// Late ready on both answers, so the slave must hold response and data
	task automatic t_slow_ready();
		b_delay = 3;
		r_delay = 3;
		write_check(32'h0000_c0f3, 4'h3, 16'hc013);
		b_delay = 0;
		r_delay = 0;
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk_i);
		error_cnt++;
		complete_run();
	end

	initial begin
		repeat (6) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		@(posedge ref_clk_i);
		t_reset();
		t_reserved();
		t_fields();
		t_unmapped();
		t_slow_ready();
		complete_run();
	end
endmodule
